// File: logic/mem_space_pkg.sv
// Purpose: constants for the memory space access decoder
// Assumes: byte addressed 16-bit data space, word addressed program space
// Notes:   sizes of implemented areas are parameters of the top module
`default_nettype none
package mem_space_pkg;
  // ------------------------------------------------------------
  // program space
  // ------------------------------------------------------------
  localparam int          PROG_ADDR_W      = 24;
  localparam int          PC_W             = 23;
  localparam logic [23:0] RESET_VECTOR     = 24'h000000;
  localparam logic [23:0] GOTO_TARGET_ADDR = 24'h000002;
  localparam logic [23:0] IVT_PRIMARY_BASE = 24'h000004;
  localparam logic [23:0] IVT_PRIMARY_END  = 24'h0000FF;
  localparam logic [23:0] IVT_ALT_BASE     = 24'h000100;
  localparam logic [23:0] IVT_ALT_END      = 24'h0001FF;
  localparam logic [23:0] VECTOR_AREA_END  = 24'h000200;
  localparam logic [22:0] PC_STEP          = 23'h000002;
  localparam int          PAGE_CFG_BIT     = 7;
  // ------------------------------------------------------------
  // data space
  // ------------------------------------------------------------
  localparam int          DATA_ADDR_W      = 16;
  localparam int          PSV_SEL_BIT      = 15;
  localparam logic [15:0] SFR_END          = 16'h07FF;
  localparam logic [15:0] NEAR_END         = 16'h1FFF;
  localparam int          NEAR_FIELD_W     = 13;
  localparam logic [15:0] RAM_BASE         = 16'h0800;
  localparam int          RAM_BYTES        = 1024;
  localparam logic [15:0] BYTE_STEP        = 16'h0001;
  localparam logic [15:0] WORD_STEP        = 16'h0002;
  localparam logic [15:0] DATA_RESET       = 16'h0000;
  // ------------------------------------------------------------
  // program fetch source
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    SRC_PC    = 2'b00,
    SRC_TABLE = 2'b01,
    SRC_PSV   = 2'b10
  } prog_src_t;
endpackage : mem_space_pkg
`default_nettype wire

// File: logic/byte_lane_ram.sv
// Purpose: word wide data ram with two byte write lanes
// Assumes: one write and one read port, read is registered
// Notes:   storage is flip-flops
`default_nettype none
module byte_lane_ram
  import mem_space_pkg::*;
#(
  parameter int WORDS = 512,
  parameter int AW    = 9
) (
  // clock and reset
  input  wire logic          mclk,
  input  wire logic          nrst,
  // write side
  input  wire logic [AW-1:0] wr_index,
  input  wire logic [1:0]    wr_lane,
  input  wire logic [15:0]   wr_data,
  // read side
  input  wire logic [AW-1:0] rd_index,
  output logic      [15:0]   rd_word
);
  logic [15:0] mem [WORDS];

  // shared word decode, separate lane strobes
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      for (int i = 0; i < WORDS; i++) begin
        mem[i] <= DATA_RESET;
      end
    end else begin
      if (wr_lane[0]) begin
        mem[wr_index][7:0] <= wr_data[7:0];
      end
      if (wr_lane[1]) begin
        mem[wr_index][15:8] <= wr_data[15:8];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      rd_word <= DATA_RESET;
    end else begin
      rd_word <= mem[rd_index];
    end
  end
endmodule : byte_lane_ram
`default_nettype wire

// File: logic/mem_space_decoder.sv
// Purpose: program and data space address decode and access
// Assumes: the cpu pipeline presents one read and one write per cycle
// Notes:   sfr contents live outside; this block routes and strobes them
`default_nettype none
module mem_space_decoder
  import mem_space_pkg::*;
#(
  parameter int RAM_SIZE = RAM_BYTES
) (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        nrst,
  // program counter control
  input  wire logic        pc_advance,
  input  wire logic        pc_retreat,
  input  wire logic        pc_load,
  input  wire logic [22:0] pc_load_value,
  // program fetch request
  input  wire prog_src_t   prog_src,
  input  wire logic [7:0]  table_page_pointer,
  input  wire logic [15:0] table_offset,
  input  wire logic [7:0]  psv_page,
  // program address out
  output logic      [22:0] program_counter,
  output logic      [23:0] prog_addr,
  output logic             prog_addr_ok,
  output logic             prog_cfg_access,
  output logic             prog_upper_word,
  output logic             prog_in_vectors,
  output logic             prog_in_ivt,
  output logic             prog_in_alt_ivt,
  // read address generation unit
  input  wire logic        rd_req,
  input  wire logic        rd_byte,
  input  wire logic        rd_direct,
  input  wire logic        rd_near,
  input  wire logic [15:0] rd_field,
  input  wire logic [15:0] rd_pointer,
  input  wire logic        rd_postmod,
  output logic      [15:0] rd_effective_address,
  output logic      [15:0] rd_pointer_next,
  output logic             rd_psv,
  output logic             rd_sfr,
  // write address generation unit
  input  wire logic        wr_req,
  input  wire logic        wr_byte,
  input  wire logic        wr_direct,
  input  wire logic        wr_near,
  input  wire logic [15:0] wr_field,
  input  wire logic [15:0] wr_pointer,
  input  wire logic        wr_postmod,
  input  wire logic [15:0] wr_data,
  output logic      [15:0] wr_effective_address,
  output logic      [15:0] wr_pointer_next,
  output logic             wr_sfr,
  output logic      [1:0]  sfr_wr_lane,
  // special function register read data
  input  wire logic [15:0] sfr_rd_word,
  input  wire logic        sfr_rd_hit,
  // psv read data
  input  wire logic [15:0] psv_rd_word,
  // read result
  output logic      [15:0] rd_data,
  output logic             rd_valid,
  // working register byte load
  input  wire logic [15:0] source_working_register,
  output logic      [15:0] wreg_merged,
  // exception handshake
  output logic             addr_error_req,
  input  wire logic        addr_error_ack
);
  localparam int RAM_WORDS = RAM_SIZE / 2;
  localparam int RAM_AW    = $clog2(RAM_WORDS);

  // ------------------------------------------------------------
  // program counter
  // ------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      program_counter <= RESET_VECTOR[22:0];
    end else if (pc_load) begin
      program_counter <= {pc_load_value[22:1], 1'b0};
    end else if (pc_advance) begin
      program_counter <= program_counter + PC_STEP;
    end else if (pc_retreat) begin
      program_counter <= program_counter - PC_STEP;
    end
  end

  // ------------------------------------------------------------
  // program address formation
  // ------------------------------------------------------------
  logic [23:0] next_prog_addr;
  logic        next_cfg;

  always_comb begin
    next_cfg = 1'b0;
    unique case (prog_src)
      SRC_PC: begin
        next_prog_addr = {1'b0, program_counter};
      end
      SRC_TABLE: begin
        next_prog_addr = {table_page_pointer, table_offset};
        next_cfg = table_page_pointer[PAGE_CFG_BIT];
      end
      SRC_PSV: begin
        // window reach stays in user half
        next_prog_addr = {1'b0, psv_page[6:0], psv_page[7] ? 16'h0001 : 16'h0000}
                         | {8'h00, rd_effective_address[14:0], 1'b0};
      end
      default: begin
        next_prog_addr = 24'h000000;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      prog_addr       <= RESET_VECTOR;
      prog_cfg_access <= 1'b0;
    end else begin
      prog_addr       <= next_prog_addr;
      prog_cfg_access <= next_cfg;
    end
  end

  // upper half only through table config reach
  assign prog_addr_ok    = !prog_addr[PROG_ADDR_W-1] || prog_cfg_access;
  assign prog_upper_word = prog_addr[0];
  assign prog_in_vectors = prog_addr < VECTOR_AREA_END;
  assign prog_in_ivt     = prog_addr >= IVT_PRIMARY_BASE && prog_addr <= IVT_PRIMARY_END;
  assign prog_in_alt_ivt = prog_addr >= IVT_ALT_BASE && prog_addr <= IVT_ALT_END;

  // ------------------------------------------------------------
  // read and write address generation
  // ------------------------------------------------------------
  // two independent generators: read and write addresses never share logic
  always_comb begin
    if (rd_direct) begin
      rd_effective_address = rd_near ? {3'b000, rd_field[NEAR_FIELD_W-1:0]} : rd_field;
    end else begin
      rd_effective_address = rd_pointer;
    end
  end

  always_comb begin
    if (wr_direct) begin
      wr_effective_address = wr_near ? {3'b000, wr_field[NEAR_FIELD_W-1:0]} : wr_field;
    end else begin
      wr_effective_address = wr_pointer;
    end
  end

  assign rd_pointer_next = rd_postmod ? rd_pointer + (rd_byte ? BYTE_STEP : WORD_STEP) : rd_pointer;
  assign wr_pointer_next = wr_postmod ? wr_pointer + (wr_byte ? BYTE_STEP : WORD_STEP) : wr_pointer;

  // ------------------------------------------------------------
  // region decode
  // ------------------------------------------------------------
  logic rd_misalign;
  logic wr_misalign;
  logic rd_in_ram;
  logic wr_in_ram;

  assign rd_psv      = rd_effective_address[PSV_SEL_BIT];
  assign rd_sfr      = !rd_psv && rd_effective_address <= SFR_END;
  assign wr_sfr      = !wr_effective_address[PSV_SEL_BIT] && wr_effective_address <= SFR_END;
  assign rd_in_ram   = !rd_psv && rd_effective_address >= RAM_BASE
                       && rd_effective_address < RAM_BASE + 16'(RAM_SIZE);
  assign wr_in_ram   = !wr_effective_address[PSV_SEL_BIT] && wr_effective_address >= RAM_BASE
                       && wr_effective_address < RAM_BASE + 16'(RAM_SIZE);
  assign rd_misalign = rd_req && !rd_byte && rd_effective_address[0];
  assign wr_misalign = wr_req && !wr_byte && wr_effective_address[0];

  // ------------------------------------------------------------
  // byte lane strobes
  // ------------------------------------------------------------
  logic [1:0]  wr_lane;
  logic [15:0] wr_lane_data;

  always_comb begin
    wr_lane = 2'b00;
    if (wr_req && !wr_misalign) begin
      if (wr_byte) begin
        wr_lane = wr_effective_address[0] ? 2'b10 : 2'b01;
      end else begin
        wr_lane = 2'b11;
      end
    end
  end

  // byte data replicated so either lane sees it
  assign wr_lane_data = wr_byte ? {wr_data[7:0], wr_data[7:0]} : wr_data;
  assign sfr_wr_lane  = wr_sfr ? wr_lane : 2'b00;

  logic [RAM_AW-1:0] ram_wr_index;
  logic [RAM_AW-1:0] ram_rd_index;
  logic [15:0]       ram_rd_word;
  logic [15:0]       wr_ram_off;
  logic [15:0]       rd_ram_off;

  assign wr_ram_off   = wr_effective_address - RAM_BASE;
  assign rd_ram_off   = rd_effective_address - RAM_BASE;
  assign ram_wr_index = wr_ram_off[RAM_AW:1];
  assign ram_rd_index = rd_ram_off[RAM_AW:1];

  byte_lane_ram #(
    .WORDS (RAM_WORDS),
    .AW    (RAM_AW)
  ) byte_lane_ram_i (
    .mclk     (mclk),
    .nrst     (nrst),
    .wr_index (ram_wr_index),
    .wr_lane  (wr_in_ram ? wr_lane : 2'b00),
    .wr_data  (wr_lane_data),
    .rd_index (ram_rd_index),
    .rd_word  (ram_rd_word)
  );

  // ------------------------------------------------------------
  // read return path
  // ------------------------------------------------------------
  logic        rd_req_q;
  logic        rd_byte_q;
  logic        rd_odd_q;
  logic [1:0]  rd_region_q;
  logic [15:0] sfr_word_q;
  logic [15:0] psv_word_q;
  logic [15:0] word_sel;

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      rd_req_q    <= 1'b0;
      rd_byte_q   <= 1'b0;
      rd_odd_q    <= 1'b0;
      rd_region_q <= 2'b00;
      sfr_word_q  <= DATA_RESET;
      psv_word_q  <= DATA_RESET;
    end else begin
      rd_req_q    <= rd_req;
      rd_byte_q   <= rd_byte;
      rd_odd_q    <= rd_effective_address[0];
      rd_region_q <= rd_psv ? 2'b11 : rd_in_ram ? 2'b01 : (rd_sfr && sfr_rd_hit) ? 2'b10 : 2'b00;
      sfr_word_q  <= sfr_rd_word;
      psv_word_q  <= psv_rd_word;
    end
  end

  always_comb begin
    unique case (rd_region_q)
      2'b01:   word_sel = ram_rd_word;
      2'b10:   word_sel = sfr_word_q;
      2'b11:   word_sel = psv_word_q;
      default: word_sel = DATA_RESET;
    endcase
  end

  // misaligned read still completes, trap follows
  assign rd_valid = rd_req_q;
  assign rd_data  = rd_byte_q ? {8'h00, rd_odd_q ? word_sel[15:8] : word_sel[7:0]} : word_sel;
  assign wreg_merged = rd_byte_q ? {source_working_register[15:8], rd_data[7:0]} : rd_data;

  // ------------------------------------------------------------
  // address error request
  // ------------------------------------------------------------
  // new error wins over a same-cycle acknowledge so no trap is lost
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      addr_error_req <= 1'b0;
    end else if (rd_misalign || wr_misalign) begin
      addr_error_req <= 1'b1;
    end else if (addr_error_ack) begin
      addr_error_req <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  a_err_raise: assert property ((rd_misalign || wr_misalign) |=> addr_error_req)
    else $error("address error not raised");
  a_err_hold: assert property (addr_error_req && !addr_error_ack |=> addr_error_req)
    else $error("address error request dropped early");
  a_no_split_write: assert property (wr_misalign |-> wr_lane == 2'b00)
    else $error("misaligned write not suppressed");
  a_byte_lane: assert property (wr_req && wr_byte |-> $countones(wr_lane) == 1
                                && wr_lane[1] == wr_effective_address[0])
    else $error("byte write lane wrong");
  a_pc_step: assert property (pc_advance && !pc_load |=> program_counter == $past(program_counter) + PC_STEP)
    else $error("counter step wrong");
  a_pc_even: assert property (program_counter[0] == 1'b0)
    else $error("counter not word aligned");
  a_rd_zero: assert property (rd_req && !rd_psv && !rd_in_ram && !(rd_sfr && sfr_rd_hit)
                              |=> rd_data == 16'h0000)
    else $error("unimplemented read not zero");
  a_byte_high_zero: assert property (rd_req && rd_byte |=> rd_data[15:8] == 8'h00)
    else $error("byte read high byte not zero");
  a_wreg_high: assert property (rd_byte_q |-> wreg_merged[15:8] == source_working_register[15:8])
    else $error("byte load changed high byte");
  a_postmod: assert property (rd_postmod |-> rd_pointer_next == rd_pointer + (rd_byte ? 16'h0001 : 16'h0002))
    else $error("post modify step wrong");
  a_pc_src_low: assert property (prog_src == SRC_PC |=> !prog_addr[23])
    else $error("execution reached upper half");
  a_cfg_reach: assert property (prog_src == SRC_TABLE |=> prog_cfg_access == $past(table_page_pointer[7]))
    else $error("table config reach flag wrong");
  a_rd_answer: assert property (rd_req |=> rd_valid)
    else $error("read not completed");

  c_misaligned_write: cover property (wr_misalign ##1 addr_error_req);
  c_byte_read_odd: cover property (rd_req && rd_byte && rd_effective_address[0] && rd_in_ram);
  c_table_cfg: cover property (prog_src == SRC_TABLE && table_page_pointer[7] ##1 prog_addr_ok);
  c_psv_read: cover property (rd_req && rd_psv);
endmodule : mem_space_decoder
`default_nettype wire

// File: test/sfr_psv_model.sv
// Purpose: far side data source for sfr and program window reads
// Assumes: data is looked up from the read effective address in the same cycle
// Notes:   only 0x0000..0x001F answers as implemented registers
`default_nettype none
module sfr_psv_model (
  // read address from the decoder
  input  wire logic        rd_req,
  input  wire logic [15:0] rd_effective_address,
  // data returned to the decoder
  output logic      [15:0] sfr_rd_word,
  output logic             sfr_rd_hit,
  output logic      [15:0] psv_rd_word
);
  timeunit 1ns;
  timeprecision 1ns;
  // ------------------------------------------------------------
  // lookup
  // ------------------------------------------------------------
  // idle bus shows inverted junk, not a stale value the decoder could reuse
  always_comb begin
    sfr_rd_hit  = rd_req && (rd_effective_address < 16'h0020);
    sfr_rd_word = {8'h5A, rd_effective_address[7:0]};
    psv_rd_word = {rd_effective_address[7:0], 8'hA5};
    if (!rd_req) begin
      sfr_rd_word = ~sfr_rd_word;
      psv_rd_word = ~psv_rd_word;
    end
  end
endmodule : sfr_psv_model
`default_nettype wire

// File: test/test_memory_space_access_decoder.sv
// Purpose: self-checking bench for the memory space decoder
// Assumes: ram starts at 0x0800 and is cleared by reset
// Notes:   address generator rows first, then sequenced cases
`default_nettype none
module test_memory_space_access_decoder;
  import mem_space_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {
    logic byte_op, direct, near, postmod, psv, sfr;
    logic [15:0] field, pointer, ea, nxt;
  } row_t;
  logic mclk, nrst, pc_advance, pc_retreat, pc_load, rd_req, rd_byte, rd_direct, rd_near, rd_postmod;
  logic wr_req, wr_byte, wr_direct, wr_near, wr_postmod, sfr_rd_hit, rd_valid, addr_error_req, addr_error_ack;
  logic prog_addr_ok, prog_cfg_access, prog_upper_word, prog_in_vectors, prog_in_ivt, prog_in_alt_ivt;
  logic rd_psv, rd_sfr, wr_sfr;
  logic [1:0]  sfr_wr_lane, lane_got;
  logic [7:0]  table_page_pointer, psv_page;
  logic [15:0] table_offset, rd_field, rd_pointer, rd_effective_address, rd_pointer_next, wr_field, wr_pointer;
  logic [15:0] wr_data, wr_effective_address, wr_pointer_next, sfr_rd_word, psv_rd_word, rd_data;
  logic [15:0] source_working_register, wreg_merged;
  logic [22:0] pc_load_value, program_counter;
  logic [23:0] prog_addr;
  prog_src_t   prog_src;
  int          err_count;
  int          cmp_count;
  row_t        rows[7];
  // ------------------------------------------------------------
  // design and far side
  // ------------------------------------------------------------
  mem_space_decoder mem_space_decoder_i (
    .mclk(mclk), .nrst(nrst), .pc_advance(pc_advance), .pc_retreat(pc_retreat), .pc_load(pc_load),
    .pc_load_value(pc_load_value), .prog_src(prog_src), .table_page_pointer(table_page_pointer),
    .table_offset(table_offset), .psv_page(psv_page), .program_counter(program_counter), .prog_addr(prog_addr),
    .prog_addr_ok(prog_addr_ok), .prog_cfg_access(prog_cfg_access), .prog_upper_word(prog_upper_word),
    .prog_in_vectors(prog_in_vectors), .prog_in_ivt(prog_in_ivt), .prog_in_alt_ivt(prog_in_alt_ivt),
    .rd_req(rd_req), .rd_byte(rd_byte), .rd_direct(rd_direct), .rd_near(rd_near), .rd_field(rd_field),
    .rd_pointer(rd_pointer), .rd_postmod(rd_postmod), .rd_effective_address(rd_effective_address),
    .rd_pointer_next(rd_pointer_next), .rd_psv(rd_psv), .rd_sfr(rd_sfr), .wr_req(wr_req), .wr_byte(wr_byte),
    .wr_direct(wr_direct), .wr_near(wr_near), .wr_field(wr_field), .wr_pointer(wr_pointer),
    .wr_postmod(wr_postmod), .wr_data(wr_data), .wr_effective_address(wr_effective_address),
    .wr_pointer_next(wr_pointer_next), .wr_sfr(wr_sfr), .sfr_wr_lane(sfr_wr_lane), .sfr_rd_word(sfr_rd_word),
    .sfr_rd_hit(sfr_rd_hit), .psv_rd_word(psv_rd_word), .rd_data(rd_data), .rd_valid(rd_valid),
    .source_working_register(source_working_register), .wreg_merged(wreg_merged),
    .addr_error_req(addr_error_req), .addr_error_ack(addr_error_ack));
  sfr_psv_model sfr_psv_model_i (.rd_req(rd_req), .rd_effective_address(rd_effective_address),
    .sfr_rd_word(sfr_rd_word), .sfr_rd_hit(sfr_rd_hit), .psv_rd_word(psv_rd_word));
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  task automatic wrap_up();
    if (err_count == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : wrap_up
  task automatic chk(input string name, input logic [23:0] exp, input logic [23:0] got);
    cmp_count++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", name, exp, got);
      err_count++;
    end
  endtask : chk
  task automatic cyc();
    @(posedge mclk);
    #5;
  endtask : cyc
  // one read, result checked in the cycle where it stands
  task automatic rd(input logic [15:0] ea, input logic b, input logic [15:0] exp, input string name);
    cyc();
    {rd_req, rd_byte, rd_direct, rd_near, rd_postmod, rd_field} = {1'b1, b, 3'b100, ea};
    cyc();
    rd_req = 1'b0;
    chk("rd_valid", 1'b1, rd_valid);
    chk(name, exp, rd_data);
  endtask : rd
  task automatic wr(input logic [15:0] ea, input logic b, input logic [15:0] d);
    cyc();
    {wr_req, wr_byte, wr_direct, wr_postmod, wr_pointer, wr_data} = {1'b1, b, 2'b00, ea, d};
    #10 lane_got = sfr_wr_lane;
    cyc();
    wr_req = 1'b0;
  endtask : wr
  task automatic set_pc(input logic [22:0] v, input logic [2:0] flags);
    cyc();
    {pc_load, pc_load_value} = {1'b1, v};
    prog_src = SRC_PC;
    cyc();
    pc_load = 1'b0;
    cyc();
    chk("prog_addr", {1'b0, v}, prog_addr);
    chk("vector flags", flags, {prog_in_vectors, prog_in_ivt, prog_in_alt_ivt});
  endtask : set_pc
  task automatic tbl(input logic [7:0] pg, input logic [15:0] off, input logic [3:0] exp);
    cyc();
    prog_src = SRC_TABLE;
    {table_page_pointer, table_offset} = {pg, off};
    cyc();
    chk("table addr", {pg, off}, prog_addr);
    chk("cfg ok upper", exp[2:0], {prog_cfg_access, prog_addr_ok, prog_upper_word});
  endtask : tbl
  task automatic ack_error();
    cyc();
    addr_error_ack = 1'b1;
    cyc();
    addr_error_ack = 1'b0;
    chk("addr_error_req", 1'b0, addr_error_req);
  endtask : ack_error
  initial begin
    repeat (3000) @(posedge mclk);
    err_count++;
    wrap_up();
  end
  // ------------------------------------------------------------
  // sequence
  // ------------------------------------------------------------
  initial begin
    err_count = 0;
    cmp_count = 0;
    nrst = 1'b0;
    {pc_advance, pc_retreat, pc_load, pc_load_value} = '0;
    prog_src = SRC_PC;
    {table_page_pointer, table_offset, psv_page, addr_error_ack, source_working_register} = '0;
    {rd_req, rd_byte, rd_direct, rd_near, rd_field, rd_pointer, rd_postmod} = '0;
    {wr_req, wr_byte, wr_direct, wr_near, wr_field, wr_pointer, wr_postmod, wr_data} = '0;
    rows[0] = '{0, 0, 0, 1, 0, 0, 16'h0000, 16'h0800, 16'h0800, 16'h0802};
    rows[1] = '{1, 0, 0, 1, 0, 0, 16'h0000, 16'h0801, 16'h0801, 16'h0802};
    rows[2] = '{0, 0, 0, 0, 0, 1, 16'h0000, 16'h07FE, 16'h07FE, 16'h07FE};
    rows[3] = '{0, 1, 1, 0, 0, 0, 16'hFFFF, 16'h1234, 16'h1FFF, 16'h1234};
    rows[4] = '{0, 1, 0, 0, 1, 0, 16'h8001, 16'h0002, 16'h8001, 16'h0002};
    rows[5] = '{1, 0, 0, 1, 1, 0, 16'h0000, 16'hFFFF, 16'hFFFF, 16'h0000};
    rows[6] = '{0, 0, 0, 1, 0, 1, 16'h0000, 16'h0000, 16'h0000, 16'h0002};
    repeat (3) @(posedge mclk);
    #5 nrst = 1'b1;
    chk("program_counter", 23'h0, program_counter);
    chk("prog_addr", 24'h0, prog_addr);
    chk("reset flags", 2'b00, {rd_valid, addr_error_req});
    // read and write generators get rows in opposite order at once, both row 3 in the middle pass
    foreach (rows[i]) begin
      cyc();
      {rd_byte, rd_direct, rd_near, rd_postmod, rd_field, rd_pointer} =
        {rows[i].byte_op, rows[i].direct, rows[i].near, rows[i].postmod, rows[i].field, rows[i].pointer};
      {wr_byte, wr_direct, wr_near, wr_postmod, wr_field, wr_pointer} =
        {rows[6-i].byte_op, rows[6-i].direct, rows[6-i].near, rows[6-i].postmod, rows[6-i].field, rows[6-i].pointer};
      #10;
      chk("rd ea", rows[i].ea, rd_effective_address);
      chk("rd next", rows[i].nxt, rd_pointer_next);
      chk("rd psv sfr", {rows[i].psv, rows[i].sfr}, {rd_psv, rd_sfr});
      chk("wr ea", rows[6-i].ea, wr_effective_address);
      chk("wr next", rows[6-i].nxt, wr_pointer_next);
      chk("wr_sfr", rows[6-i].sfr, wr_sfr);
    end
    // program counter stepping, load priority
    cyc();
    pc_advance = 1'b1;
    repeat (3) cyc();
    {pc_advance, pc_retreat} = 2'b01;
    cyc();
    pc_retreat = 1'b0;
    chk("program_counter", 23'h4, program_counter);
    cyc();
    {pc_load, pc_advance, pc_load_value} = {2'b11, 23'h000101};
    cyc();
    {pc_load, pc_advance} = 2'b00;
    chk("program_counter", 23'h100, program_counter);
    set_pc(23'h000000, 3'b100);
    set_pc(23'h000004, 3'b110);
    set_pc(23'h000100, 3'b101);
    set_pc(23'h000200, 3'b000);
    tbl(8'h80, 16'h0005, 4'b111);
    tbl(8'h7F, 16'hFFFE, 4'b010);
    cyc();
    prog_src = SRC_PSV;
    {psv_page, rd_direct, rd_field} = {8'hFF, 1'b1, 16'hFFFE};
    cyc();
    chk("psv upper half", 1'b0, prog_addr[23]);
    // byte lanes in ram, then reads beyond ram, unmapped, sfr and psv
    wr(16'h0800, 1'b0, 16'hA1B2);
    rd(16'h0800, 1'b0, 16'hA1B2, "word read");
    wr(16'h0800, 1'b1, 16'hFF5C);
    rd(16'h0800, 1'b0, 16'hA15C, "low lane write");
    wr(16'h0803, 1'b1, 16'h0077);
    rd(16'h0802, 1'b0, 16'h7700, "high lane write");
    source_working_register = 16'hDEAD;
    rd(16'h0801, 1'b1, 16'h00A1, "byte read");
    chk("wreg_merged", 16'hDEA1, wreg_merged);
    rd(16'h0C00, 1'b0, 16'h0000, "beyond ram");
    rd(16'h2000, 1'b0, 16'h0000, "unmapped");
    rd(16'h0012, 1'b0, 16'h5A12, "sfr hit");
    rd(16'h0600, 1'b0, 16'h0000, "sfr unused");
    rd(16'h8042, 1'b0, 16'h42A5, "psv read");
    // sfr write strobes
    wr(16'h0010, 1'b0, 16'h1111);
    chk("lane word", 2'b11, lane_got);
    wr(16'h0011, 1'b1, 16'h0022);
    chk("lane hi", 2'b10, lane_got);
    wr(16'h0010, 1'b1, 16'h0022);
    chk("lane lo", 2'b01, lane_got);
    chk("addr_error_req", 1'b0, addr_error_req);
    wr(16'h0011, 1'b0, 16'h3333);
    chk("lane odd word", 2'b00, lane_got);
    chk("addr_error_req", 1'b1, addr_error_req);
    ack_error();
    // misaligned ram write suppressed, error held until acknowledged
    wr(16'h0803, 1'b0, 16'hFFFF);
    cyc();
    chk("addr_error_req", 1'b1, addr_error_req);
    ack_error();
    rd(16'h0802, 1'b0, 16'h7700, "suppressed write");
    rd(16'h0801, 1'b0, 16'hA15C, "odd word read");
    chk("addr_error_req", 1'b1, addr_error_req);
    ack_error();
    wrap_up();
  end
endmodule : test_memory_space_access_decoder
`default_nettype wire
